// file: hdl/adc_input_reference_select.sv
// What this block does
// [R01] A 10-bit unsigned result is formed by successive approximation, zero at ground, all ones at the reference.
// [R02] Bits 7:6 pick the reference: 00 external pin with internal off, 01 analog supply, 10 reserved, 11 internal 2.56V.
// [R03] Reference or channel rewrites during a conversion apply only once it completes and its flag is set.
// [R04] Bits 4:0 route an analog input combination, and pick gain on differential channels.
// [R05] Bit 5 set left-aligns the result; clear right-aligns it.
// [R06] A change of bit 5 reshapes the result register at once, even mid-conversion.
// [R07] The result sits in 16 bits: 9:0 when right-aligned, 15:6 when left-aligned, other bits zero.
`timescale 1ns/1ns
`default_nettype none
module adc_input_reference_select
	import adc_sel_pkg::*;
#(
	parameter int BITS = RESULT_BITS
)
(
	// Clock and reset
	input wire logic clock,
	input wire logic rst_b,
	// AXI4-Lite write address and data
	input wire logic [4:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [4:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Analog front end
	output adc_sel_pkg::analog_setting_t analog_setting,
	output logic [BITS-1:0] dac_trial,
	input wire logic comparator_high,
	// Interrupt
	output logic irq
);
	import adc_sel_pkg::*;

	typedef struct packed {
		logic aw_held;
		logic [4:0] aw_addr;
		logic w_held;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [7:0] input_select;
		analog_setting_t applied;
		logic pending;
		logic complete_flag;
		logic irq_mask;
		logic start;
		logic irq;
	} regs_t;
	regs_t cur, next_cur;

	logic busy, done;
	logic [BITS-1:0] trial, raw_result;
	logic [15:0] shaped;

	// [R01] SAR conversion
	sar_engine #(
		.BITS(BITS)
	) engine (
		.clock(clock),
		.rst_b(rst_b),
		.start(cur.start),
		.comparator_high(comparator_high),
		.busy(busy),
		.done(done),
		.trial(trial),
		.result(raw_result)
	);

	// Aligns a result; combinational so alignment acts with no delay
	function automatic logic [15:0] align(input logic [BITS-1:0] r,
		input logic left);
		logic [15:0] w;
		w = 16'h0000;
		w[BITS-1:0] = r;
		// [R07] Pad to 16 bits
		if (left)
			w = w << (16 - BITS);
		return w;
	endfunction : align

	// [R05] Alignment picks the shape
	// [R06] Read straight from the live bit
	assign shaped = align(raw_result, cur.input_select[ALIGN_BIT]);

	always_comb
	begin
		logic wr_go;
		logic rd_go;
		logic [31:0] wd;
		wr_go = 1'b0;
		rd_go = 1'b0;
		wd = 32'h0000_0000;
		next_cur = cur;
		next_cur.start = 1'b0;

		// Capture address and data independently, either order
		if (s_axi_awvalid && !cur.aw_held)
		begin
			next_cur.aw_held = 1'b1;
			next_cur.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !cur.w_held)
		begin
			next_cur.w_held = 1'b1;
			next_cur.w_data = s_axi_wdata;
			next_cur.w_strb = s_axi_wstrb;
		end
		wr_go = cur.aw_held && cur.w_held && !cur.bvalid;
		wd = cur.w_data;

		// A completed conversion sets the flag
		if (done)
			next_cur.complete_flag = 1'b1;

		// [R03] Held setting moves only on completion
		if (done && cur.pending)
		begin
			next_cur.applied.reference_select =
				reference_t'(cur.input_select[REF_HI:REF_LO]);
			next_cur.applied.channel_select = cur.input_select[CHAN_HI:0];
			next_cur.pending = 1'b0;
		end

		if (wr_go)
		begin
			next_cur.aw_held = 1'b0;
			next_cur.w_held = 1'b0;
			next_cur.bvalid = 1'b1;
			next_cur.bresp = RESP_OKAY;
			if (cur.aw_addr == {1'b0, OFF_INPUT_SELECT})
			begin
				if (cur.w_strb[0])
				begin
					next_cur.input_select = wd[7:0];
					// [R02] [R04] Idle: apply at once
					if (!busy && !cur.start)
					begin
						next_cur.applied.reference_select =
							reference_t'(wd[REF_HI:REF_LO]);
						next_cur.applied.channel_select = wd[CHAN_HI:0];
						next_cur.pending = 1'b0;
					end
					else
						next_cur.pending = 1'b1;
				end
			end
			else if (cur.aw_addr == {1'b0, OFF_CONTROL})
			begin
				// Bit 0 starts a conversion when idle
				if (cur.w_strb[0] && wd[0] && !busy)
					next_cur.start = 1'b1;
			end
			else if (cur.aw_addr == {1'b0, OFF_IRQ_STATUS})
			begin
				// Write one clears; a new completion wins
				if (cur.w_strb[0] && wd[0] && !done)
					next_cur.complete_flag = 1'b0;
			end
			else if (cur.aw_addr == OFF_IRQ_MASK_FULL)
			begin
				if (cur.w_strb[0])
					next_cur.irq_mask = wd[0];
			end
			else if (cur.aw_addr != {1'b0, OFF_RESULT})
				next_cur.bresp = RESP_SLVERR;
		end
		if (cur.bvalid && s_axi_bready)
			next_cur.bvalid = 1'b0;

		// Read decode
		rd_go = s_axi_arvalid && !cur.rvalid;
		if (rd_go)
		begin
			next_cur.rvalid = 1'b1;
			next_cur.rresp = RESP_OKAY;
			next_cur.rdata = 32'h0000_0000;
			if (s_axi_araddr == {1'b0, OFF_INPUT_SELECT})
				next_cur.rdata[7:0] = cur.input_select;
			else if (s_axi_araddr == {1'b0, OFF_CONTROL})
				next_cur.rdata[1] = busy | cur.start;
			else if (s_axi_araddr == {1'b0, OFF_RESULT})
				next_cur.rdata[15:0] = shaped;
			else if (s_axi_araddr == {1'b0, OFF_IRQ_STATUS})
				next_cur.rdata[0] = cur.complete_flag;
			else if (s_axi_araddr == OFF_IRQ_MASK_FULL)
				next_cur.rdata[0] = cur.irq_mask;
			else
				next_cur.rresp = RESP_SLVERR;
		end
		else if (cur.rvalid && s_axi_rready)
			next_cur.rvalid = 1'b0;

		next_cur.irq = next_cur.complete_flag & next_cur.irq_mask;
	end

	// Single state register
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			cur <= '0;
			cur.input_select <= INPUT_SELECT_RESET;
		end
		else
			cur <= next_cur;
	end

	// Outputs straight from flip-flops
	assign s_axi_awready = !cur.aw_held;
	assign s_axi_wready = !cur.w_held;
	assign s_axi_bvalid = cur.bvalid;
	assign s_axi_bresp = cur.bresp;
	assign s_axi_arready = !cur.rvalid;
	assign s_axi_rvalid = cur.rvalid;
	assign s_axi_rdata = cur.rdata;
	assign s_axi_rresp = cur.rresp;
	assign analog_setting = cur.applied;
	assign dac_trial = trial; // Engine flop: no lag, comparator judges this bit
	assign irq = cur.irq;
endmodule : adc_input_reference_select
`default_nettype wire

// file: hdl/sar_engine.sv
`timescale 1ns/1ns
`default_nettype none
module sar_engine
	import adc_sel_pkg::*;
#(
	parameter int BITS = 10
)
(
	// Clock and reset
	input wire logic clock,
	input wire logic rst_b,
	// Control
	input wire logic start,
	// Comparator answer from the analog core
	input wire logic comparator_high,
	// Status and result
	output logic busy,
	output logic done,
	output logic [BITS-1:0] trial,
	output logic [BITS-1:0] result
);
	typedef struct packed {
		sar_state_t state;
		logic [BITS-1:0] trial;
		logic [BITS-1:0] bit_mask;
		logic [BITS-1:0] result;
		logic done;
	} sar_regs_t;
	sar_regs_t cur, next_cur;

	// One bit decided per cycle, most significant first
	always_comb
	begin
		next_cur = cur;
		next_cur.done = 1'b0;
		case (cur.state)
			SAR_IDLE:
			begin
				if (start)
				begin
					next_cur.state = SAR_RUN;
					next_cur.bit_mask = {1'b1, {(BITS-1){1'b0}}};
					next_cur.trial = {1'b1, {(BITS-1){1'b0}}};
				end
			end
			SAR_RUN:
			begin
				// Trial above input: drop this bit
				if (comparator_high)
					next_cur.trial = cur.trial & ~cur.bit_mask;
				next_cur.bit_mask = cur.bit_mask >> 1;
				next_cur.trial = next_cur.trial | (cur.bit_mask >> 1);
				if (cur.bit_mask[0])
					next_cur.state = SAR_DONE;
			end
			SAR_DONE:
			begin
				next_cur.result = cur.trial;
				next_cur.done = 1'b1;
				next_cur.state = SAR_IDLE;
			end
			default:
				next_cur.state = SAR_IDLE;
		endcase
	end

	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
			cur <= '0;
		else
			cur <= next_cur;
	end

	assign busy = cur.state != SAR_IDLE;
	assign done = cur.done;
	assign trial = cur.trial;
	assign result = cur.result;
endmodule : sar_engine
`default_nettype wire

// file: pkg/adc_sel_pkg.sv
`default_nettype none
package adc_sel_pkg;
	// Register byte offsets on the AXI4-Lite bus
	localparam logic [3:0] OFF_INPUT_SELECT = 4'h0;
	localparam logic [3:0] OFF_CONTROL = 4'h4;
	localparam logic [3:0] OFF_RESULT = 4'h8;
	localparam logic [3:0] OFF_IRQ_STATUS = 4'hc;
	localparam logic [3:0] OFF_IRQ_MASK = 4'h0;
	localparam logic [4:0] OFF_IRQ_MASK_FULL = 5'h10;
	// Field positions of the input select register
	localparam int REF_HI = 7;
	localparam int REF_LO = 6;
	localparam int ALIGN_BIT = 5;
	localparam int CHAN_HI = 4;
	// Reset value and sizes
	localparam logic [7:0] INPUT_SELECT_RESET = 8'h00;
	localparam int RESULT_BITS = 10;
	localparam int SAR_CYCLES = 13;
	// Bus response codes
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	// Reference encodings
	typedef enum logic [1:0] {
		REF_EXTERNAL = 2'b00,
		REF_SUPPLY = 2'b01,
		REF_RESERVED = 2'b10,
		REF_INTERNAL = 2'b11
	} reference_t;
	// Setting applied to the analog front end
	typedef struct packed {
		reference_t reference_select;
		logic [4:0] channel_select;
	} analog_setting_t;
	typedef enum logic [1:0] {
		SAR_IDLE = 2'b00,
		SAR_RUN = 2'b01,
		SAR_DONE = 2'b10
	} sar_state_t;
endpackage : adc_sel_pkg
`default_nettype wire

// file: tb/adc_input_reference_select_bench.sv
`timescale 1ns/1ns
`default_nettype none
module adc_input_reference_select_bench;
	import adc_sel_pkg::*;
	localparam logic [4:0] A_SEL = {1'b0, OFF_INPUT_SELECT};
	localparam logic [4:0] A_CTL = {1'b0, OFF_CONTROL};
	localparam logic [4:0] A_RES = {1'b0, OFF_RESULT};
	localparam logic [4:0] A_STAT = {1'b0, OFF_IRQ_STATUS};
	logic clock, rst_b, awv, awr, wv, wr_, bv, brd, arv, arr, rv, rrd, cmp, irq;
	logic [4:0] awa, ara;
	logic [31:0] wd, rdat, rd;
	logic [3:0] ws;
	logic [1:0] br, rr, resp;
	logic [9:0] trial;
	analog_setting_t setting;
	int bad_count, tests_run, n;
	// Design and far side
	adc_input_reference_select i_dut (.clock(clock), .rst_b(rst_b),
		.s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
		.s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
		.s_axi_wready(wr_), .s_axi_bresp(br), .s_axi_bvalid(bv),
		.s_axi_bready(brd), .s_axi_araddr(ara), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr),
		.s_axi_rvalid(rv), .s_axi_rready(rrd), .analog_setting(setting),
		.dac_trial(trial), .comparator_high(cmp), .irq(irq));
	analog_core_model i_core (.analog_setting(setting), .dac_trial(trial),
		.comparator_high(cmp));
	// Clock
	always #50 clock = ~clock;
	// Write; an idle edge at the end keeps bready from a double drive
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		brd <= 1'b1;
		do
		begin
			@(posedge clock);
			if (awr) awv <= 1'b0;
			if (wr_) wv <= 1'b0;
		end while (!bv);
		resp = br;
		brd <= 1'b0;
		@(posedge clock);
	endtask : wr
	// Read
	task automatic rd_(input logic [4:0] a);
		ara <= a;
		arv <= 1'b1;
		rrd <= 1'b1;
		do
		begin
			@(posedge clock);
			if (arr) arv <= 1'b0;
		end while (!rv);
		rd = rdat;
		resp = rr;
		rrd <= 1'b0;
		@(posedge clock);
	endtask : rd_
	task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e)
		begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", w, e, g);
		end
	endtask : chk
	task automatic test_done;
		$display("comparisons %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : test_done
	// Watchdog against a hung handshake
	initial
	begin
		#(3000 * 100);
		bad_count++;
		test_done();
	end
	// Tests
	initial
	begin
		{clock, rst_b, awv, wv, brd, arv, rrd, awa, ara, wd} = '0;
		ws = 4'hf;
		repeat (4) @(posedge clock);
		rst_b <= 1'b1;
		@(posedge clock);
		rd_(A_SEL);
		chk("select reset", 32'h0000_0000, rd);
		for (int r = 0; r < 4; r++)
		begin
			wr(A_SEL, 32'(r * 64 + 3));
			rd_(A_SEL);
			chk("select", 32'(r * 64 + 3), rd);
			chk("setting", 32'(r * 32 + 3), 32'(setting));
		end
		$display("select test done");
		wr(A_CTL, 32'h0000_0001);
		rd_(A_CTL);
		chk("busy", 32'h0000_0002, rd);
		wr(A_SEL, 32'h0000_0059);
		chk("held", 32'h0000_0063, 32'(setting));
		// Poll the flag; a poll that runs out fails the flag check
		n = 0;
		do
		begin
			rd_(A_STAT);
			n++;
		end while (!rd[0] && n < 40);
		chk("flag", 32'h0000_0001, rd);
		chk("applied", 32'h0000_0039, 32'(setting));
		rd_(A_CTL);
		chk("idle", 32'h0000_0000, rd);
		rd_(A_RES);
		chk("right", 32'h0000_02e3, rd);
		wr(A_RES, 32'hffff_ffff);
		chk("result write resp", 32'(RESP_OKAY), 32'(resp));
		rd_(A_RES);
		chk("result ro", 32'h0000_02e3, rd);
		chk("irq masked", 32'h0000_0000, 32'(irq));
		wr(OFF_IRQ_MASK_FULL, 32'h0000_0001);
		chk("irq on", 32'h0000_0001, 32'(irq));
		wr(A_STAT, 32'h0000_0001);
		chk("irq off", 32'h0000_0000, 32'(irq));
		$display("convert test done");
		wr(A_CTL, 32'h0000_0001);
		wr(A_SEL, 32'h0000_0079);
		rd_(A_RES);
		chk("left now", 32'h0000_b8c0, rd);
		for (n = 0; n < 40 && !irq; n++) @(posedge clock);
		chk("irq again", 32'h0000_0001, 32'(irq));
		rd_(A_RES);
		chk("left new", 32'h0000_ae40, rd);
		$display("align test done");
		rd_(5'h14);
		chk("bad read resp", 32'(RESP_SLVERR), 32'(resp));
		chk("bad read data", 32'h0000_0000, rd);
		wr(5'h14, 32'h0000_0001);
		chk("bad write", 32'(RESP_SLVERR), 32'(resp));
		$display("decode test done");
		test_done();
	end
endmodule : adc_input_reference_select_bench
`default_nettype wire

// file: tb/adc_sel_sva.sv
`timescale 1ns/1ns
`default_nettype none
module adc_sel_sva
(
	// Clock and reset
	input wire logic clock,
	input wire logic rst_b,
	// Bus handshakes
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);
	// Both halves of a write taken together
	sequence write_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	a_write_answer: assert property (write_taken |-> ##2 s_axi_bvalid)
		else $error("write response late");
	a_aw_held: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
		else $error("address slot not held");
	a_b_stands: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready
		|=> s_axi_rvalid)
		else $error("read answer late");
	a_read_once: assert property (s_axi_rvalid && s_axi_rready
		|=> !s_axi_rvalid)
		else $error("read answer repeated");
	a_write_once: assert property (s_axi_bvalid && s_axi_bready
		|=> !s_axi_bvalid)
		else $error("write response repeated");
	a_r_stands: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while answer pending");
	a_upper_zero: assert property (s_axi_rvalid |-> !(|s_axi_rdata[31:16]))
		else $error("upper read bits set");
endmodule : adc_sel_sva
bind adc_input_reference_select adc_sel_sva i_sva (.clock(clock), .rst_b(rst_b),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
`default_nettype wire

// file: tb/analog_core_model.sv
`timescale 1ns/1ns
`default_nettype none
module analog_core_model
(
	// Front end view
	input wire adc_sel_pkg::analog_setting_t analog_setting,
	input wire logic [9:0] dac_trial,
	// Comparator answer
	output logic comparator_high
);
	import adc_sel_pkg::*;
	// Level follows the route, so a route swapped mid-conversion shows
	// level from reference and channel
	assign comparator_high = dac_trial > {3'b101, analog_setting};
endmodule : analog_core_model
`default_nettype wire
